// ==== tsr_defines.svh ====
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// ****************************************
// banks and top-of-map offsets
// ****************************************
`define TSR_BANK_TUNE        8'h00
`define TSR_BANK_BASELINE    8'h02
`define TSR_ADDR_BANK_SEL    8'hF0
`define TSR_ADDR_INPUT_CNT   8'hF1
`define TSR_ADDR_PRODUCT0    8'hF7
`define TSR_ADDR_PRODUCT1    8'hF8
`define TSR_ADDR_PRODUCT2    8'hF9
`define TSR_ADDR_PRODUCT3    8'hFA
`define TSR_ADDR_MAKER0      8'hFB
`define TSR_ADDR_MAKER1      8'hFC
`define TSR_ADDR_BUILD       8'hFD
`define TSR_ADDR_MINOR       8'hFE
`define TSR_ADDR_MAJOR       8'hFF

// ****************************************
// bank 2 baseline start offsets, sensor 0 is the proximity loop
// ****************************************
`define TSR_BASE_ADDR0       8'h10
`define TSR_BASE_ADDR1       8'h13
`define TSR_BASE_ADDR2       8'h16
`define TSR_BASE_ADDR3       8'h19
`define TSR_BASE_ADDR4       8'h22
`define TSR_BASE_ADDR5       8'h25

// ****************************************
// bank 0 tuning and state offsets
// ****************************************
`define TSR_ADDR_DEBOUNCE    8'hC2
`define TSR_ADDR_THRESH0     8'h80
`define TSR_ADDR_SCALE0      8'h88
`define TSR_ADDR_DELTA0      8'h90
`define TSR_ADDR_TOUCH       8'h98
`define TSR_ADDR_CAL         8'h99
`define TSR_ADDR_GAIN        8'h9A

// ****************************************
// reset values
// ****************************************
`define TSR_RST_BANK         8'h00
`define TSR_RST_INPUT_CNT    8'h06
`define TSR_RST_BASELINE     24'h00_0000
`define TSR_RST_DEBOUNCE     8'h00
`define TSR_RST_THRESH       8'h10
`define TSR_RST_SCALE        4'h0
`define TSR_RST_GAIN         2'h0
`define TSR_RST_CAL          6'h3F

`endif

// ==== tsr_pkg.sv ====
package tsr_pkg;
  typedef logic [7:0]  tsr_byte_t;
  typedef logic [23:0] tsr_reading_t;
  typedef logic [5:0]  tsr_mask_t;
endpackage

// ==== tsr_register_map.sv ====
`include "tsr_defines.svh"

// Behaviour
// - Bank 2 holds a read-only 24-bit baseline per sensor, three bytes each, zero after reset.
// - The bank-select byte is read/write and it and the top-of-map bytes answer in every bank.
// - The input-count byte always reads six.
// - A fixed 32-bit product code reads over four bytes, least significant byte first.
// - A fixed 16-bit maker code reads over two bytes, least significant byte first.
// - Build, minor and major version bytes read as fixed values at successive addresses.
// - The touch mask has bit 0 for the proximity loop and bits 1 to 5 for the buttons, one meaning touched.
// - Each sensor's deviation is kept as an 8-bit two's complement value.
// - Touch is decided by comparing each sensor's deviation with its own threshold byte.
// - The calibration mask has bit 0 for the proximity loop and bits 1 to 5 for buttons, one meaning running.
// - Writing a one to a calibration mask bit starts calibration of that sensor.
// - A scale factor of 0 to 15 per sensor sets sensitivity, lower values being more sensitive.
// - A gain of 0 to 3 sets the low-pass filter applied to the readings.
// - A touch is raised only after the programmed 1 to 255 consecutive samples beyond the threshold.
module tsr_register_map #(
  parameter logic [31:0] PRODUCT_CODE  = 32'h5A5A_0102,  // arbitrary value
  parameter logic [15:0] MAKER_CODE    = 16'h3C3C,       // arbitrary value
  parameter logic [7:0]  BUILD_NUMBER  = 8'h07,          // arbitrary value
  parameter logic [7:0]  MINOR_VERSION = 8'h02,          // arbitrary value
  parameter logic [7:0]  MAJOR_VERSION = 8'h03           // arbitrary value
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   sampleStrobe,
  input  wire logic [5:0][23:0]       rawReading,
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regWrEn,
  input  wire tsr_pkg::tsr_byte_t     regWrData,
  input  wire logic                   regRdEn,
  output      tsr_pkg::tsr_byte_t     regRdData,
  output      logic                   regRdValid,
  output      tsr_pkg::tsr_mask_t     touchMask
);
  import tsr_pkg::*;

  // ****************************************
  // constants
  // ****************************************
  localparam int NSENS = 6;
  localparam logic [5:0][7:0] BASE_ADDR = {`TSR_BASE_ADDR5, `TSR_BASE_ADDR4, `TSR_BASE_ADDR3,
                                           `TSR_BASE_ADDR2, `TSR_BASE_ADDR1, `TSR_BASE_ADDR0};

  // ****************************************
  // state
  // ****************************************
  tsr_byte_t       bankQ;
  tsr_byte_t       debounceQ;
  logic [1:0]      gainQ;
  tsr_mask_t       calQ;
  tsr_mask_t       touchQ;
  tsr_byte_t       rdDataQ;
  logic            rdValidQ;
  tsr_reading_t    filtQ     [NSENS];
  tsr_reading_t    baseQ     [NSENS];
  tsr_byte_t       threshQ   [NSENS];
  logic [3:0]      scaleQ    [NSENS];
  tsr_byte_t       deltaQ    [NSENS];
  tsr_byte_t       cntQ      [NSENS];

  // ****************************************
  // decode
  // ****************************************
  wire         topHit     = (regAddr >= `TSR_ADDR_BANK_SEL);
  wire         inTune     = !topHit && (bankQ == `TSR_BANK_TUNE);
  wire         inBase     = !topHit && (bankQ == `TSR_BANK_BASELINE);
  wire         wrBank     = regWrEn && (regAddr == `TSR_ADDR_BANK_SEL);
  wire         wrDebounce = regWrEn && inTune && (regAddr == `TSR_ADDR_DEBOUNCE);
  wire         wrGain     = regWrEn && inTune && (regAddr == `TSR_ADDR_GAIN);
  wire         wrCal      = regWrEn && inTune && (regAddr == `TSR_ADDR_CAL);
  wire [2:0]   perIdx     = regAddr[2:0];
  wire         perOk      = (perIdx < 3'd6);
  wire         thrBlk     = inTune && perOk && (regAddr[7:3] == 5'(`TSR_ADDR_THRESH0 >> 3));
  wire         sclBlk     = inTune && perOk && (regAddr[7:3] == 5'(`TSR_ADDR_SCALE0 >> 3));
  wire         dltBlk     = inTune && perOk && (regAddr[7:3] == 5'(`TSR_ADDR_DELTA0 >> 3));
  // zero is taken as one so a touch can never be raised without a qualifying sample
  wire [7:0]   dbLimit    = (debounceQ == 8'h00) ? 8'h01 : debounceQ;
  wire [5:0]   calSet     = wrCal ? regWrData[5:0] : 6'h00;

  // ****************************************
  // per-sensor datapath
  // ****************************************
  logic [5:0]  calDone;
  tsr_byte_t   baseByte [NSENS];

  genvar g;
  generate
    for (g = 0; g < NSENS; g++) begin : gSens
      wire signed [24:0] rawDiff  = $signed({1'b0, rawReading[g]}) - $signed({1'b0, filtQ[g]});
      wire signed [24:0] filtStep = rawDiff >>> ({1'b0, gainQ} + 3'd1);
      wire [23:0]        filtNext = filtQ[g] + filtStep[23:0];
      wire signed [24:0] devRaw   = $signed({1'b0, filtQ[g]}) - $signed({1'b0, baseQ[g]});
      wire signed [24:0] devScl   = devRaw >>> scaleQ[g];
      wire               posSat   = (devScl > 25'sd127);
      wire               negSat   = (devScl < -25'sd128);
      wire [7:0]         devByte  = posSat ? 8'h7F : (negSat ? 8'h80 : devScl[7:0]);
      wire               beyond   = $signed(deltaQ[g]) > $signed({1'b0, threshQ[g]});
      wire               wrThr    = regWrEn && thrBlk && (perIdx == 3'(g));
      wire               wrScl    = regWrEn && sclBlk && (perIdx == 3'(g));
      wire [7:0]         offs     = regAddr - BASE_ADDR[g];
      wire               bHit     = inBase && (regAddr >= BASE_ADDR[g]) && (offs < 8'd3);

      // little endian within the three bytes of each baseline
      assign baseByte[g] = !bHit ? 8'h00 :
                           (offs == 8'd0) ? baseQ[g][7:0] :
                           (offs == 8'd1) ? baseQ[g][15:8] : baseQ[g][23:16];
      assign calDone[g]  = sampleStrobe && calQ[g];

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          filtQ[g]   <= `TSR_RST_BASELINE;
          baseQ[g]   <= `TSR_RST_BASELINE;
          threshQ[g] <= `TSR_RST_THRESH;
          scaleQ[g]  <= `TSR_RST_SCALE;
          deltaQ[g]  <= 8'h00;
          cntQ[g]    <= 8'h00;
        end else begin
          if (wrThr) begin
            threshQ[g] <= regWrData;
          end
          if (wrScl) begin
            scaleQ[g] <= regWrData[3:0];
          end
          if (sampleStrobe) begin
            filtQ[g]  <= filtNext;
            deltaQ[g] <= devByte;
            if (calQ[g]) begin
              baseQ[g] <= filtNext;
            end
            if (beyond && !calQ[g]) begin
              if (cntQ[g] != 8'hFF) begin
                cntQ[g] <= cntQ[g] + 8'h01;
              end
            end else begin
              cntQ[g] <= 8'h00;
            end
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          touchQ[g] <= 1'b0;
        end else if (sampleStrobe) begin
          // cntQ+1 is the count including the sample being taken now
          touchQ[g] <= beyond && !calQ[g] && ((9'(cntQ[g]) + 9'd1) >= 9'(dbLimit));
        end
      end
    end
  endgenerate

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] baseOr;
  always_comb begin
    baseOr = 8'h00;
    for (int i = 0; i < NSENS; i++) begin
      baseOr = baseOr | baseByte[i];
    end
  end

  wire [7:0] topByte =
      (regAddr == `TSR_ADDR_BANK_SEL)  ? bankQ               :
      (regAddr == `TSR_ADDR_INPUT_CNT) ? `TSR_RST_INPUT_CNT  :
      (regAddr == `TSR_ADDR_PRODUCT0)  ? PRODUCT_CODE[7:0]   :
      (regAddr == `TSR_ADDR_PRODUCT1)  ? PRODUCT_CODE[15:8]  :
      (regAddr == `TSR_ADDR_PRODUCT2)  ? PRODUCT_CODE[23:16] :
      (regAddr == `TSR_ADDR_PRODUCT3)  ? PRODUCT_CODE[31:24] :
      (regAddr == `TSR_ADDR_MAKER0)    ? MAKER_CODE[7:0]     :
      (regAddr == `TSR_ADDR_MAKER1)    ? MAKER_CODE[15:8]    :
      (regAddr == `TSR_ADDR_BUILD)     ? BUILD_NUMBER        :
      (regAddr == `TSR_ADDR_MINOR)     ? MINOR_VERSION       :
      (regAddr == `TSR_ADDR_MAJOR)     ? MAJOR_VERSION       : 8'h00;

  wire [7:0] tuneByte =
      thrBlk                             ? threshQ[perIdx]         :
      sclBlk                             ? {4'h0, scaleQ[perIdx]}  :
      dltBlk                             ? deltaQ[perIdx]          :
      (regAddr == `TSR_ADDR_TOUCH)       ? {2'b00, touchQ}         :
      (regAddr == `TSR_ADDR_CAL)         ? {2'b00, calQ}           :
      (regAddr == `TSR_ADDR_GAIN)        ? {6'h00, gainQ}          :
      (regAddr == `TSR_ADDR_DEBOUNCE)    ? debounceQ               : 8'h00;

  wire [7:0] rdMux = topHit ? topByte : (inTune ? tuneByte : baseOr);

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bankQ     <= `TSR_RST_BANK;
      debounceQ <= `TSR_RST_DEBOUNCE;
      gainQ     <= `TSR_RST_GAIN;
    end else begin
      if (wrBank) begin
        bankQ <= regWrData;
      end
      if (wrDebounce) begin
        debounceQ <= regWrData;
      end
      if (wrGain) begin
        gainQ <= regWrData[1:0];
      end
    end
  end

  // a host start in the same cycle as a completion wins, so no request is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      calQ <= `TSR_RST_CAL;
    end else begin
      calQ <= (calQ & ~calDone) | calSet;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ  <= 8'h00;
      rdValidQ <= 1'b0;
    end else begin
      rdValidQ <= regRdEn;
      if (regRdEn) begin
        rdDataQ <= rdMux;
      end
    end
  end

  assign regRdData  = rdDataQ;
  assign regRdValid = rdValidQ;
  assign touchMask  = touchQ;

endmodule

// ==== tsr_register_map_chk.sv ====
module tsr_register_map_chk #(
  parameter logic [31:0] PRODUCT_CODE  = 32'h1111_1111, // arbitrary
  parameter logic [15:0] MAKER_CODE    = 16'h2222,      // arbitrary
  parameter logic [7:0]  BUILD_NUMBER  = 8'h33,         // arbitrary
  parameter logic [7:0]  MINOR_VERSION = 8'h44,         // arbitrary
  parameter logic [7:0]  MAJOR_VERSION = 8'h55          // arbitrary
) (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               sampleStrobe,
  input wire logic [7:0]         regAddr,
  input wire logic               regWrEn,
  input wire tsr_pkg::tsr_byte_t regWrData,
  input wire logic               regRdEn,
  input wire tsr_pkg::tsr_byte_t regRdData,
  input wire logic               regRdValid,
  input wire tsr_pkg::tsr_mask_t touchMask
);
  timeunit 1ns;
  timeprecision 100ps;
  import tsr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // fixed identity bytes from 0xF7 upward
  // ****************************************
  function automatic tsr_byte_t idb(input logic [7:0] a);
    logic [71:0] t;
    t = {MAJOR_VERSION, MINOR_VERSION, BUILD_NUMBER, MAKER_CODE, PRODUCT_CODE};
    return t[(a - 8'hF7) * 8 +: 8];
  endfunction
  property p_rdValid; regRdEn |=> regRdValid; endproperty
  a_rdValid: assert property (p_rdValid) else $error("read without valid");
  property p_noValid; !regRdEn |=> !regRdValid; endproperty
  a_noValid: assert property (p_noValid) else $error("valid without read");
  property p_count; regRdEn && regAddr == 8'hF1 |=> regRdData == 8'h06; endproperty
  a_count: assert property (p_count) else $error("input count wrong");
  property p_id; regRdEn && regAddr >= 8'hF7 |=> regRdData == idb($past(regAddr)); endproperty
  a_id: assert property (p_id) else $error("identity byte wrong");
  property p_bank;
    regWrEn && regAddr == 8'hF0 ##1 !regWrEn ##1 regRdEn && !regWrEn && regAddr == 8'hF0
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_bank: assert property (p_bank) else $error("bank readback wrong");
  property p_hold; !regRdEn |=> $stable(regRdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_gap; regRdEn && regAddr inside {[8'hF2:8'hF6]} |=> regRdData == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped byte not zero");
  // touch state only moves with a sample
  property p_touch; !sampleStrobe |=> $stable(touchMask); endproperty
  a_touch: assert property (p_touch) else $error("touch moved without sample");
  cover property ($rose(|touchMask));
  cover property (regWrEn && regAddr == 8'hF0);
  cover property (regRdValid && regRdData != 8'h00);
endmodule

bind tsr_register_map tsr_register_map_chk #(.PRODUCT_CODE(PRODUCT_CODE), .MAKER_CODE(MAKER_CODE),
  .BUILD_NUMBER(BUILD_NUMBER), .MINOR_VERSION(MINOR_VERSION), .MAJOR_VERSION(MAJOR_VERSION)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sampleStrobe(sampleStrobe), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
  .touchMask(touchMask));

// ==== tsr_host_model.sv ====
module tsr_host_model (
  input  wire logic               core_clk,
  output      logic [7:0]         regAddr,
  output      logic               regWrEn,
  output      tsr_pkg::tsr_byte_t regWrData,
  output      logic               regRdEn,
  input  wire tsr_pkg::tsr_byte_t regRdData,
  input  wire logic               regRdValid
);
  timeunit 1ns;
  timeprecision 100ps;
  import tsr_pkg::*;
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input tsr_byte_t d);
    @(posedge core_clk) #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge core_clk) #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output tsr_byte_t d);
    int n;
    @(posedge core_clk) #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk) #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    for (n = 0; n < 4 && regRdValid !== 1'b1; n++) @(posedge core_clk) #1;
    if (n == 4) begin
      touch_sensor_register_map_tb.failures++;
      touch_sensor_register_map_tb.summarize();
    end else begin
      d = regRdData;
    end
  endtask
endmodule

// ==== touch_sensor_register_map_tb.sv ====
module touch_sensor_register_map_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsr_pkg::*;
  localparam logic [31:0] PC = 32'h5A5A_0102; // arbitrary
  localparam logic [15:0] MC = 16'h3C3C;      // arbitrary
  localparam logic [23:0] VR = 24'h03_0207;   // arbitrary
  logic core_clk, rst_n, sampleStrobe, regWrEn, regRdEn, regRdValid;
  logic [5:0][23:0] rawReading;
  logic [7:0]       regAddr, a, v;
  tsr_byte_t        regWrData, regRdData, d;
  tsr_mask_t        touchMask, expT, cm;
  logic signed [24:0] ff;
  logic [23:0]      base [6];
  tsr_byte_t        thr [6];
  logic [3:0]       sc [6];
  int failures, checks_done, seed, g, n, i, b, t, m;
  tsr_register_map #(.PRODUCT_CODE(PC), .MAKER_CODE(MC), .BUILD_NUMBER(VR[7:0]), .MINOR_VERSION(VR[15:8]),
    .MAJOR_VERSION(VR[23:16])) u_dut (.core_clk(core_clk), .rst_n(rst_n), .sampleStrobe(sampleStrobe),
    .rawReading(rawReading), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid), .touchMask(touchMask));
  tsr_host_model u_host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));
  always #2.5 core_clk = ~core_clk;
  function automatic tsr_byte_t topExp(input logic [7:0] x, input tsr_byte_t bank);
    logic [71:0] id;
    id = {VR, MC, PC};
    if (x == 8'hF0) return bank;
    if (x == 8'hF1) return 8'h06;
    if (x >= 8'hF7) return id[(x - 8'hF7) * 8 +: 8];
    return 8'h00;
  endfunction
  task automatic chk(input tsr_byte_t got, input tsr_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] x, input tsr_byte_t exp);
    u_host.rd(x, d);
    chk(d, exp);
  endtask
  // one sample, then one more edge so the result has landed
  task automatic strobe();
    @(posedge core_clk) #1;
    sampleStrobe = 1'b1;
    @(posedge core_clk) #1;
    sampleStrobe = 1'b0;
    ff = ff + ((25'(signed'({1'b0, rawReading[0]})) - ff) >>> (g + 1));
    @(posedge core_clk) #1;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    sampleStrobe = 1'b0;
    rawReading = '0;
    ff = '0;
    g = 0;
    failures = 0;
    checks_done = 0;
    seed = 32'h98f9_7db0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    u_host.wr(8'hF1, 8'($random(seed)));
    u_host.wr(8'hFF, 8'($random(seed)));
    v = 8'($random(seed));
    u_host.wr(8'hF0, v);
    rdc(8'hF0, v);
    for (b = 0; b < 3; b += 2) begin
      u_host.wr(8'hF0, 8'(b));
      for (a = 8'hF0; a != 8'h00; a++) rdc(a, topExp(a, 8'(b)));
    end
    u_host.wr(8'h14, 8'hFF);
    for (a = 8'h10; a < 8'h28; a++) rdc(a, 8'h00);
    u_host.wr(8'hF0, 8'h00);
    rdc(8'h99, 8'h3F);
    g = $unsigned($random(seed)) % 4;
    u_host.wr(8'h9A, 8'(g));
    for (t = 0; t < 3; t++) begin
      // decay to zero, then recalibrate all so every trial starts from a flat baseline
      rawReading = '0;
      repeat (200) strobe();
      u_host.wr(8'h99, 8'h3F);
      strobe();
      rdc(8'h99, 8'h00);
      chk(8'(touchMask), 8'h00);
      m = (t == 0) ? 0 : (t == 1) ? 255 : 1 + $unsigned($random(seed)) % 8;
      u_host.wr(8'hC2, 8'(m));
      m = (m == 0) ? 1 : m;
      for (i = 0; i < 6; i++) begin
        base[i] = ff[23:0];
        thr[i] = (i == t + 1) ? 8'h7F : 8'($random(seed)) & 8'h7E;
        sc[i] = $random(seed) & 1 ? 4'hF : 4'h0;
        expT[i] = thr[i] != 8'h7F && sc[i] == 4'h0;
        u_host.wr(8'h80 + 8'(i), thr[i]);
        u_host.wr(8'h88 + 8'(i), 8'(sc[i]));
        rdc(8'h80 + 8'(i), thr[i]);
      end
      rawReading = {6{24'h00_1000}};
      // delta lags the filter by one sample and touch lags the delta by one
      for (n = 1; n <= m + 2; n++) begin
        strobe();
        if (n == m + 1) chk(8'(touchMask), 8'h00);
      end
      chk(8'(touchMask), 8'(expT));
      rdc(8'h98, 8'(expT));
      for (i = 0; i < 6; i++) rdc(8'h90 + 8'(i), sc[i] == 4'h0 ? 8'h7F : 8'h00);
      cm = 6'($random(seed)) | 6'h01;
      u_host.wr(8'h99, 8'(cm));
      rdc(8'h99, 8'(cm));
      strobe();
      rdc(8'h99, 8'h00);
      u_host.wr(8'hF0, 8'h02);
      for (i = 0; i < 6; i++) begin
        if (cm[i]) base[i] = ff[23:0];
        a = (i < 4) ? 8'h10 + 8'(3 * i) : 8'h22 + 8'(3 * (i - 4));
        for (b = 0; b < 3; b++) rdc(a + 8'(b), base[i][8 * b +: 8]);
      end
      u_host.wr(8'hF0, 8'h00);
    end
    summarize();
  end
endmodule
